// >>> tb/hvpp_port_asserts.sv
`timescale 1ns/1ns
module hvpp_port_asserts (
   input wire logic        CLOCK,
   input wire logic        RST_N,
   input wire logic        PROG_HV,
   input wire logic        LOAD_STROBE,
   input wire logic        OUTPUT_ENABLE_N,
   input wire logic        WRITE_PULSE_N,
   input wire logic        BYTE_SELECT_FIRST,
   input wire logic        STROBE_ACTION_BIT0,
   input wire logic        STROBE_ACTION_BIT1,
   input wire logic        PAGE_LOAD,
   input wire logic        DATA_OE,
   input wire logic        READY_BUSY_OUT,
   input wire logic        PROG_MODE,
   input wire logic [15:0] RD_ADDR,
   input wire logic        NVM_VALID,
   input wire logic        NVM_IDLE
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   logic sig_ok;
   assign sig_ok = {PAGE_LOAD, STROBE_ACTION_BIT1, STROBE_ACTION_BIT0, BYTE_SELECT_FIRST}
                   == hvpp_pkg::ENTRY_SIGNATURE;
   property p_oe; DATA_OE == $past(!OUTPUT_ENABLE_N && PROG_MODE); endproperty
   a_oe: assert property (p_oe) else $error("oe mismatch");
   property p_rdy; READY_BUSY_OUT |-> !NVM_VALID; endproperty
   a_rdy: assert property (p_rdy) else $error("ready with op");
   property p_rise; $rose(READY_BUSY_OUT) |-> $past(NVM_IDLE) && !$past(NVM_VALID); endproperty
   a_rise: assert property (p_rise) else $error("early ready");
   property p_fall;
      $fell(READY_BUSY_OUT) |-> $past(WRITE_PULSE_N, 2) && !$past(WRITE_PULSE_N);
   endproperty
   a_fall: assert property (p_fall) else $error("busy without write");
   property p_entry; $rose(PROG_HV) && sig_ok |=> PROG_MODE; endproperty
   a_entry: assert property (p_entry) else $error("mode not entered");
   property p_noentry; $rose(PROG_HV) && !sig_ok |=> !PROG_MODE [*3]; endproperty
   a_noentry: assert property (p_noentry) else $error("bad entry");
   property p_exit; !PROG_HV |=> !PROG_MODE; endproperty
   a_exit: assert property (p_exit) else $error("mode kept");
   property p_addr; (!LOAD_STROBE) [*3] |-> $stable(RD_ADDR); endproperty
   a_addr: assert property (p_addr) else $error("address drift");
   c_entry: cover property ($rose(PROG_MODE));
   c_busy: cover property ($fell(READY_BUSY_OUT));
   c_read: cover property (DATA_OE);
endmodule
bind hvpp_port hvpp_port_asserts u_hvpp_port_asserts (.CLOCK(CLOCK), .RST_N(RST_N),
   .PROG_HV(PROG_HV), .LOAD_STROBE(LOAD_STROBE), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
   .WRITE_PULSE_N(WRITE_PULSE_N), .BYTE_SELECT_FIRST(BYTE_SELECT_FIRST),
   .STROBE_ACTION_BIT0(STROBE_ACTION_BIT0), .STROBE_ACTION_BIT1(STROBE_ACTION_BIT1),
   .PAGE_LOAD(PAGE_LOAD), .DATA_OE(DATA_OE), .READY_BUSY_OUT(READY_BUSY_OUT),
   .PROG_MODE(PROG_MODE), .RD_ADDR(RD_ADDR), .NVM_VALID(NVM_VALID), .NVM_IDLE(NVM_IDLE));

// >>> tb/nvm_model.sv
`timescale 1ns/1ns
module nvm_model #(
   parameter logic [15:0] SIG_WORD = 16'h5aa5  // Arbitrary value
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                slow,
   input  wire hvpp_pkg::rd_space_e rd_space,
   input  wire logic [15:0]         rd_addr,
   output logic [15:0]              rd_data,
   input  wire logic                nvm_valid,
   input  wire hvpp_pkg::nvm_op_s   nvm_op,
   output logic                     nvm_ready,
   output logic                     nvm_idle
);
   logic [15:0] flash [0:16383];
   logic [7:0]  ee    [0:1023];
   logic [1:0]  busy;
   initial foreach (flash[i]) flash[i] = 16'hffff;
   initial foreach (ee[i]) ee[i] = 8'hff;
   assign nvm_ready = busy == 2'h0;
   assign nvm_idle  = busy == 2'h0;
   always_comb begin
      case (rd_space)
         hvpp_pkg::SPACE_FLASH:  rd_data = flash[rd_addr[13:0]];
         hvpp_pkg::SPACE_EEPROM: rd_data = {8'hff, ee[rd_addr[9:0]]};
         default:                rd_data = SIG_WORD;
      endcase
   end
   // Slow ops let the feed fill
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 2'h0;
      end else if (nvm_valid && nvm_ready) begin
         busy <= slow ? 2'h3 : 2'h1;
         case (nvm_op.op)
            hvpp_pkg::OP_FLASH_WORD:  flash[nvm_op.addr[13:0]] <= nvm_op.data;
            hvpp_pkg::OP_EEPROM_BYTE: ee[nvm_op.addr[9:0]] <= nvm_op.data[7:0];
            hvpp_pkg::OP_ERASE_FLASH: foreach (flash[i]) flash[i] <= 16'hffff;
            hvpp_pkg::OP_ERASE_EE:    foreach (ee[i]) ee[i] <= 8'hff;
            default: ;
         endcase
      end else if (busy != 2'h0) begin
         busy <= busy - 2'h1;
      end
   end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic CLOCK = 0, RST_N = 0, PROG_HV = 0, LOAD_STROBE = 0, PAGE_LOAD = 0, slow = 0;
   logic OUTPUT_ENABLE_N = 1, WRITE_PULSE_N = 1, BYTE_SELECT_FIRST = 0, BYTE_SELECT_SECOND = 0;
   logic STROBE_ACTION_BIT0 = 0, STROBE_ACTION_BIT1 = 0;
   logic [7:0] DATA_IN = 8'h00, DATA_OUT;
   logic DATA_OE, READY_BUSY_OUT, PROG_MODE, NVM_VALID, NVM_READY, NVM_IDLE;
   logic [15:0] RD_ADDR, RD_DATA, w;
   hvpp_pkg::rd_space_e RD_SPACE;
   hvpp_pkg::nvm_op_s   NVM_OP;
   int seed = 32'h8e29, miscompares = 0, checks = 0, cycles = 0;
   logic [7:0]  fz [4];
   logic [15:0] mem [logic [16:0]];
   hvpp_port u_hvpp_port (.CLOCK(CLOCK), .RST_N(RST_N), .PROG_HV(PROG_HV),
      .LOAD_STROBE(LOAD_STROBE), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
      .WRITE_PULSE_N(WRITE_PULSE_N), .BYTE_SELECT_FIRST(BYTE_SELECT_FIRST),
      .BYTE_SELECT_SECOND(BYTE_SELECT_SECOND), .STROBE_ACTION_BIT0(STROBE_ACTION_BIT0),
      .STROBE_ACTION_BIT1(STROBE_ACTION_BIT1), .PAGE_LOAD(PAGE_LOAD), .DATA_IN(DATA_IN),
      .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .READY_BUSY_OUT(READY_BUSY_OUT),
      .PROG_MODE(PROG_MODE), .RD_SPACE(RD_SPACE), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
      .NVM_VALID(NVM_VALID), .NVM_OP(NVM_OP), .NVM_READY(NVM_READY), .NVM_IDLE(NVM_IDLE));
   nvm_model u_nvm_model (.clk(CLOCK), .rst_n(RST_N), .slow(slow), .rd_space(RD_SPACE),
      .rd_addr(RD_ADDR), .rd_data(RD_DATA), .nvm_valid(NVM_VALID), .nvm_op(NVM_OP),
      .nvm_ready(NVM_READY), .nvm_idle(NVM_IDLE));
   always #25 CLOCK = ~CLOCK;
   task stop_test;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge CLOCK) if (++cycles == 40000) begin
      miscompares++;
      stop_test;
   end
   task cmp(input logic [15:0] got, logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task idle_chk;
      cmp({DATA_OUT, 4'h0, NVM_VALID, DATA_OE, READY_BUSY_OUT, PROG_MODE}, 16'hff02);
   endtask
   task cyc(input int n); repeat (n) @(negedge CLOCK); endtask
   // Five cycles make 250 ns
   task ld(input logic [1:0] xa, logic bs, logic [7:0] d);
      {STROBE_ACTION_BIT1, STROBE_ACTION_BIT0} = xa;
      BYTE_SELECT_FIRST = bs;
      DATA_IN = d;
      cyc(1); LOAD_STROBE = 1; cyc(5); LOAD_STROBE = 0; cyc(5);
   endtask
   task cmd(input logic [7:0] c); ld(2'h2, 1'b0, c); endtask
   task adr(input logic [15:0] x); ld(2'h0, 1, x[15:8]); ld(2'h0, 0, x[7:0]); endtask
   task wr(input logic busy);
      WRITE_PULSE_N = 0; cyc(2);
      cmp(16'(READY_BUSY_OUT), 16'(!busy));
      cyc(3); WRITE_PULSE_N = 1;
      for (int i = 0; i < 3000 && READY_BUSY_OUT !== 1'b1; i++) cyc(1);
      cmp(16'(READY_BUSY_OUT), 16'h1);
   endtask
   task rd(input logic [1:0] bs, logic [7:0] exp);
      {BYTE_SELECT_SECOND, BYTE_SELECT_FIRST} = bs;
      DATA_IN = ~DATA_IN;
      OUTPUT_ENABLE_N = 0; cyc(4);
      cmp({7'h0, DATA_OE, DATA_OUT}, {8'h01, exp});
      OUTPUT_ENABLE_N = 1; cyc(2);
      cmp(16'(DATA_OE), 16'h0);
   endtask
   task chk_fuses;
      cmd(hvpp_pkg::CMD_READ_FUSE);
      ld(2'h3, 1'b0, hvpp_pkg::CMD_READ_FLASH);
      rd(2'h0, fz[0]); rd(2'h3, fz[1]); rd(2'h2, fz[2]); rd(2'h1, fz[3]);
   endtask
   task wfuse(input int k, logic [7:0] v);
      cmd(hvpp_pkg::CMD_WRITE_FUSE);
      ld(2'h1, 1'b0, v);
      {BYTE_SELECT_SECOND, BYTE_SELECT_FIRST} = 2'(k);
      wr(1'b1);
      {BYTE_SELECT_SECOND, BYTE_SELECT_FIRST} = 2'h0;
      fz[k] = v;
   endtask
   task page(input logic ee);
      logic [15:0] base;
      logic [7:0]  idx;
      base = 16'($random(seed)) & (ee ? 16'h03fc : 16'h3fc0);
      slow = !ee;
      cmd(ee ? hvpp_pkg::CMD_WRITE_EEPROM : hvpp_pkg::CMD_WRITE_FLASH);
      adr(base);
      for (int k = 0; k < 4; k++) begin
         w = ee ? {8'hff, 8'($random(seed))} : 16'($random(seed));
         idx = ee ? 8'(k) : 8'(k * 21);
         ld(2'h0, 1'b0, base[7:0] | idx);
         ld(2'h1, 1'b0, w[7:0]); ld(2'h1, 1'b1, w[15:8]);
         PAGE_LOAD = 1; cyc(5); PAGE_LOAD = 0; cyc(5);
         mem[{ee, base | 16'(idx)}] = w;
      end
      if (!ee) mem[{1'b0, base + 16'h1}] = hvpp_pkg::ERASED_WORD;
      BYTE_SELECT_FIRST = 0;
      wr(1'b1);
   endtask
   task verify(input logic ee);
      cmd(ee ? hvpp_pkg::CMD_READ_EEPROM : hvpp_pkg::CMD_READ_FLASH);
      foreach (mem[x]) if (x[16] == ee) begin
         adr(x[15:0]);
         rd(2'h0, mem[x][7:0]);
         if (!ee) rd(2'h1, mem[x][15:8]);
      end
   endtask
   task erase;
      cmd(hvpp_pkg::CMD_CHIP_ERASE);
      wr(1'b1);
      foreach (mem[x])
         if (!x[16] || fz[1][hvpp_pkg::PRESERVE_EE_BIT]) mem[x] = hvpp_pkg::ERASED_WORD;
      fz[3] = hvpp_pkg::LOCK_RESET;
      verify(0); verify(1); chk_fuses();
   endtask
   initial begin
      cyc(8); RST_N = 1; cyc(1);
      idle_chk;
      BYTE_SELECT_FIRST = 1; cyc(400); PROG_HV = 1; cyc(4);
      cmp(16'(PROG_MODE), 16'h0);
      PROG_HV = 0; BYTE_SELECT_FIRST = 0; cyc(4);
      PROG_HV = 1; cyc(2);
      cmp(16'(PROG_MODE), 16'h1);
      cyc(6000);
      fz = '{hvpp_pkg::FUSE_LOW_RESET, hvpp_pkg::FUSE_HIGH_RESET, hvpp_pkg::FUSE_EXT_RESET,
             hvpp_pkg::LOCK_RESET};
      chk_fuses;
      cmd(hvpp_pkg::CMD_READ_SIG); rd(2'h1, 8'h5a);
      for (int k = 0; k < 3; k++) begin
         w = 16'($random(seed));
         wfuse(k, (k == 1) ? (w[7:0] | 8'h08) : w[7:0]);
      end
      chk_fuses();
      cmd(hvpp_pkg::CMD_READ_FLASH); wr(1'b0);
      page(0); verify(0); page(1); verify(1);
      w = 16'($random(seed)) | 16'h0003;
      cmd(hvpp_pkg::CMD_WRITE_LOCK); ld(2'h1, 1'b0, w[7:0]); wr(1'b1);
      fz[3] = fz[3] & w[7:0];
      chk_fuses();
      erase();
      wfuse(1, fz[1] & 8'hf7);
      page(1); erase();
      PROG_HV = 0; cyc(3);
      cmp(16'(PROG_MODE), 16'h0);
      RST_N = 0; cyc(2); RST_N = 1; cyc(1);
      idle_chk;
      stop_test;
   end
endmodule

// >>> verilog/hvpp_pkg.sv
package hvpp_pkg;

   // Strobe-action codes
   localparam logic [1:0] XA_ADDR = 2'h0;
   localparam logic [1:0] XA_DATA = 2'h1;
   localparam logic [1:0] XA_CMD  = 2'h2;
   localparam logic [1:0] XA_IDLE = 2'h3;

   // {page_load, strobe_action_bit1, strobe_action_bit0, byte_select_first} at entry
   localparam logic [3:0] ENTRY_SIGNATURE = 4'h0;

   // Command bytes
   localparam logic [7:0] CMD_NOP          = 8'h00;
   localparam logic [7:0] CMD_CHIP_ERASE   = 8'h80;
   localparam logic [7:0] CMD_WRITE_FUSE   = 8'h40;
   localparam logic [7:0] CMD_WRITE_LOCK   = 8'h20;
   localparam logic [7:0] CMD_WRITE_FLASH  = 8'h10;
   localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
   localparam logic [7:0] CMD_READ_SIG     = 8'h08;
   localparam logic [7:0] CMD_READ_FUSE    = 8'h04;
   localparam logic [7:0] CMD_READ_FLASH   = 8'h02;
   localparam logic [7:0] CMD_READ_EEPROM  = 8'h03;

   // Geometry
   localparam int         EE_PAGE_BYTES = 4;
   localparam int         EE_INDEX_BITS = 2;

   // Erased and reset values (1 means unprogrammed)
   localparam logic [15:0] ERASED_WORD      = 16'hffff;
   localparam logic [7:0]  ERASED_BYTE      = 8'hff;
   localparam logic [7:0]  FUSE_LOW_RESET   = 8'h62;
   localparam logic [7:0]  FUSE_HIGH_RESET  = 8'hdf;
   localparam logic [7:0]  FUSE_EXT_RESET   = 8'hff;
   localparam logic [7:0]  LOCK_RESET       = 8'hff;
   localparam int          PRESERVE_EE_BIT  = 3;

   typedef enum logic [2:0] {
      OP_FLASH_WORD  = 3'h0,
      OP_EEPROM_BYTE = 3'h1,
      OP_FUSE_LOW    = 3'h2,
      OP_FUSE_HIGH   = 3'h3,
      OP_FUSE_EXT    = 3'h4,
      OP_LOCK        = 3'h5,
      OP_ERASE_FLASH = 3'h6,
      OP_ERASE_EE    = 3'h7
   } nvm_op_e;

   typedef enum logic [1:0] {
      SPACE_FLASH  = 2'h0,
      SPACE_EEPROM = 2'h1,
      SPACE_SIG    = 2'h2
   } rd_space_e;

   typedef struct packed {
      nvm_op_e     op;
      logic [15:0] addr;
      logic [15:0] data;
   } nvm_op_s;

endpackage

// >>> verilog/hvpp_port.sv
`timescale 1ns/1ns

module nvm_fifo #(
   parameter int WIDTH = 35,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready,
   output logic                  empty
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [CW-1:0]               cnt;
      logic                        ov;
      logic [WIDTH-1:0]            od;
   } fifo_s;

   fifo_s s;
   fifo_s next_s;
   logic  push;
   logic  take;
   logic  load;

   assign in_ready  = (s.cnt != CW'(DEPTH));
   assign out_valid = s.ov;
   assign out_data  = s.od;
   assign empty     = (s.cnt == '0) && !s.ov;

   always_comb begin
      next_s = s;
      push   = in_valid && in_ready;
      take   = s.ov && out_ready;
      load   = (s.cnt != '0) && (!s.ov || take);
      if (take) begin
         next_s.ov = 1'b0;
      end
      // Output word held in a register stage
      if (load) begin
         next_s.od = s.mem[s.rp];
         next_s.ov = 1'b1;
         next_s.rp = s.rp + AW'(1);
      end
      if (push) begin
         next_s.mem[s.wp] = in_data;
         next_s.wp        = s.wp + AW'(1);
      end
      next_s.cnt = s.cnt + CW'(push) - CW'(load);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// Operation
// - Ready/busy low while writing or erasing, high when a command is accepted.
// - Data bus driven only while output enable is low.
// - First byte select picks low byte at 0, high byte at 1.
// - Second byte select picks low byte at 0, extended byte at 1.
// - Load strobe rise acts per action code: address, data, command, nothing.
// - Address load goes to high byte when first select is 1, else low.
// - Write pulse or output enable executes the latest loaded command.
// - Commands 0x10 write flash, 0x11 write EEPROM, 0x02 read flash.
// - Commands 0x08 read signature, 0x04 read fuse and lock, 0x03 read EEPROM.
// - Commands 0x40 write fuses, 0x20 write lock bits.
// - Programming mode ends on power down or reset pin at 0V.
// - Loaded command and address persist across many accesses.
// - Chip erase clears flash and lock bits, and EEPROM unless the preserve fuse is programmed, keeps fuses.
// - Lock bits cleared only after program memory fully erased.
// - Chip erase keeps EEPROM when the preserve fuse is programmed.
// - Flash written a page at a time through a page buffer.
// - EEPROM pages are four bytes, two low address bits index the byte.
// - Page load rise latches loaded data into page buffer at current index.
module hvpp_port #(
   parameter int PAGE_WORD_BITS = 6,
   parameter int FIFO_DEPTH     = 16
) (
   input  wire logic                    CLOCK,
   input  wire logic                    RST_N,
   input  wire logic                    PROG_HV,
   input  wire logic                    LOAD_STROBE,
   input  wire logic                    OUTPUT_ENABLE_N,
   input  wire logic                    WRITE_PULSE_N,
   input  wire logic                    BYTE_SELECT_FIRST,
   input  wire logic                    BYTE_SELECT_SECOND,
   input  wire logic                    STROBE_ACTION_BIT0,
   input  wire logic                    STROBE_ACTION_BIT1,
   input  wire logic                    PAGE_LOAD,
   input  wire logic [7:0]              DATA_IN,
   output logic      [7:0]              DATA_OUT,
   output logic                         DATA_OE,
   output logic                         READY_BUSY_OUT,
   output logic                         PROG_MODE,
   output hvpp_pkg::rd_space_e          RD_SPACE,
   output logic      [15:0]             RD_ADDR,
   input  wire logic [15:0]             RD_DATA,
   output logic                         NVM_VALID,
   output hvpp_pkg::nvm_op_s            NVM_OP,
   input  wire logic                    NVM_READY,
   input  wire logic                    NVM_IDLE
);
   localparam int PAGE_WORDS = 1 << PAGE_WORD_BITS;
   localparam int OP_W       = $bits(hvpp_pkg::nvm_op_s);

   typedef enum logic [5:0] {
      ST_IDLE   = 6'b000001,
      ST_FLASH  = 6'b000010,
      ST_EE     = 6'b000100,
      ST_SINGLE = 6'b001000,
      ST_ERASE  = 6'b010000,
      ST_DRAIN  = 6'b100000
   } state_e;

   typedef struct packed {
      state_e                            st;
      logic                              prog;
      logic                              hv_d;
      logic                              strobe_d;
      logic                              wr_d;
      logic                              page_load_d;
      logic [7:0]                        cmd;
      logic [7:0]                        addr_lo;
      logic [7:0]                        addr_hi;
      logic [7:0]                        data_lo;
      logic [7:0]                        data_hi;
      logic [PAGE_WORDS-1:0][15:0]       page;
      logic [hvpp_pkg::EE_PAGE_BYTES-1:0][7:0] ee_page;
      logic [PAGE_WORD_BITS-1:0]         step;
      logic                              erase;
      logic                              fuse_sel_hi;
      logic                              fuse_sel_ext;
      logic [7:0]                        fuse_lo;
      logic [7:0]                        fuse_hi;
      logic [7:0]                        fuse_ext;
      logic [7:0]                        lock;
      logic                              rdy;
      logic                              oe;
      logic [7:0]                        dout;
      hvpp_pkg::rd_space_e               space;
      logic [15:0]                       raddr;
   } state_s;

   state_s                s;
   state_s                next_s;
   logic                  push_valid;
   hvpp_pkg::nvm_op_s     push_op;
   logic                  push_ready;
   logic                  fifo_empty;
   logic [OP_W-1:0]       fifo_out;
   logic                  strobe_rise;
   logic                  wr_fall;
   logic                  page_load_rise;
   logic [15:0]           word_addr;
   logic [PAGE_WORD_BITS-1:0] word_in_page_index;
   logic [hvpp_pkg::EE_INDEX_BITS-1:0] eeprom_byte_address;

   nvm_fifo #(
      .WIDTH (OP_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLOCK),
      .rst_n     (RST_N),
      .in_valid  (push_valid),
      .in_data   (push_op),
      .in_ready  (push_ready),
      .out_valid (NVM_VALID),
      .out_data  (fifo_out),
      .out_ready (NVM_READY),
      .empty     (fifo_empty)
   );

   assign NVM_OP          = hvpp_pkg::nvm_op_s'(fifo_out);
   assign DATA_OUT        = s.dout;
   assign DATA_OE         = s.oe;
   assign READY_BUSY_OUT  = s.rdy;
   assign PROG_MODE       = s.prog;
   assign RD_SPACE        = s.space;
   assign RD_ADDR         = s.raddr;

   assign strobe_rise         = LOAD_STROBE && !s.strobe_d;
   assign wr_fall             = !WRITE_PULSE_N && s.wr_d;
   assign page_load_rise          = PAGE_LOAD && !s.page_load_d;
   assign word_addr           = {s.addr_hi, s.addr_lo};
   assign word_in_page_index  = s.addr_lo[PAGE_WORD_BITS-1:0];
   assign eeprom_byte_address = s.addr_lo[hvpp_pkg::EE_INDEX_BITS-1:0];

   always_comb begin
      next_s     = s;
      push_valid = 1'b0;
      push_op    = '0;
      next_s.hv_d     = PROG_HV;
      next_s.strobe_d = LOAD_STROBE;
      next_s.wr_d     = WRITE_PULSE_N;
      next_s.page_load_d  = PAGE_LOAD;
      if (PROG_HV && !s.hv_d && !s.prog && {PAGE_LOAD, STROBE_ACTION_BIT1,
            STROBE_ACTION_BIT0, BYTE_SELECT_FIRST} == hvpp_pkg::ENTRY_SIGNATURE) begin
         next_s.prog = 1'b1;
      end
      if (!PROG_HV) begin
         // Reset pin at 0V ends mode
         next_s.prog  = 1'b0;
         next_s.st    = ST_IDLE;
         next_s.cmd   = hvpp_pkg::CMD_NOP;
         next_s.erase = 1'b0;
      end else if (s.prog) begin
         case (s.st)
            ST_IDLE: begin
               if (strobe_rise) begin
                  case ({STROBE_ACTION_BIT1, STROBE_ACTION_BIT0})
                     hvpp_pkg::XA_ADDR: begin
                        if (BYTE_SELECT_FIRST) begin
                           next_s.addr_hi = DATA_IN;
                        end else begin
                           next_s.addr_lo = DATA_IN;
                        end
                     end
                     hvpp_pkg::XA_DATA: begin
                        if (BYTE_SELECT_FIRST) begin
                           next_s.data_hi = DATA_IN;
                        end else begin
                           next_s.data_lo = DATA_IN;
                        end
                     end
                     hvpp_pkg::XA_CMD: begin
                        next_s.cmd = DATA_IN;
                     end
                     default: begin
                     end
                  endcase
               end
               if (page_load_rise) begin
                  if (s.cmd == hvpp_pkg::CMD_WRITE_FLASH) begin
                     next_s.page[word_in_page_index] = {s.data_hi, s.data_lo};
                  end else if (s.cmd == hvpp_pkg::CMD_WRITE_EEPROM) begin
                     next_s.ee_page[eeprom_byte_address] = s.data_lo;
                  end
               end
               if (wr_fall) begin
                  next_s.step = '0;
                  case (s.cmd)
                     hvpp_pkg::CMD_WRITE_FLASH: begin
                        next_s.st = ST_FLASH;
                     end
                     hvpp_pkg::CMD_WRITE_EEPROM: begin
                        next_s.st = ST_EE;
                     end
                     hvpp_pkg::CMD_WRITE_FUSE, hvpp_pkg::CMD_WRITE_LOCK: begin
                        next_s.st           = ST_SINGLE;
                        next_s.fuse_sel_hi  = BYTE_SELECT_FIRST && !BYTE_SELECT_SECOND;
                        next_s.fuse_sel_ext = !BYTE_SELECT_FIRST && BYTE_SELECT_SECOND;
                     end
                     hvpp_pkg::CMD_CHIP_ERASE: begin
                        next_s.st    = ST_ERASE;
                        next_s.erase = 1'b1;
                     end
                     default: begin
                     end
                  endcase
               end
            end
            ST_FLASH: begin
               // Whole page streamed out word by word
               push_valid   = 1'b1;
               push_op.op   = hvpp_pkg::OP_FLASH_WORD;
               push_op.addr = {word_addr[15:PAGE_WORD_BITS], s.step};
               push_op.data = s.page[s.step];
               if (push_ready) begin
                  next_s.step = s.step + PAGE_WORD_BITS'(1);
                  if (s.step == PAGE_WORD_BITS'(PAGE_WORDS - 1)) begin
                     next_s.page = {PAGE_WORDS{hvpp_pkg::ERASED_WORD}};
                     next_s.st   = ST_DRAIN;
                  end
               end
            end
            ST_EE: begin
               push_valid   = 1'b1;
               push_op.op   = hvpp_pkg::OP_EEPROM_BYTE;
               push_op.addr = {word_addr[15:hvpp_pkg::EE_INDEX_BITS],
                               s.step[hvpp_pkg::EE_INDEX_BITS-1:0]};
               push_op.data = {8'h00, s.ee_page[s.step[hvpp_pkg::EE_INDEX_BITS-1:0]]};
               if (push_ready) begin
                  next_s.step = s.step + PAGE_WORD_BITS'(1);
                  if (s.step == PAGE_WORD_BITS'(hvpp_pkg::EE_PAGE_BYTES - 1)) begin
                     next_s.ee_page = {hvpp_pkg::EE_PAGE_BYTES{hvpp_pkg::ERASED_BYTE}};
                     next_s.st      = ST_DRAIN;
                  end
               end
            end
            ST_SINGLE: begin
               push_valid   = 1'b1;
               push_op.data = {8'h00, s.data_lo};
               if (s.cmd == hvpp_pkg::CMD_WRITE_LOCK) begin
                  push_op.op = hvpp_pkg::OP_LOCK;
               end else if (s.fuse_sel_hi) begin
                  push_op.op = hvpp_pkg::OP_FUSE_HIGH;
               end else if (s.fuse_sel_ext) begin
                  push_op.op = hvpp_pkg::OP_FUSE_EXT;
               end else begin
                  push_op.op = hvpp_pkg::OP_FUSE_LOW;
               end
               if (push_ready) begin
                  next_s.st = ST_DRAIN;
                  case (push_op.op)
                     // Erase alone clears lock bits
                     hvpp_pkg::OP_LOCK:      next_s.lock     = s.lock & s.data_lo;
                     hvpp_pkg::OP_FUSE_HIGH: next_s.fuse_hi  = s.data_lo;
                     hvpp_pkg::OP_FUSE_EXT:  next_s.fuse_ext = s.data_lo;
                     default:                next_s.fuse_lo  = s.data_lo;
                  endcase
               end
            end
            ST_ERASE: begin
               push_valid = 1'b1;
               if (s.step == '0) begin
                  push_op.op = hvpp_pkg::OP_ERASE_FLASH;
                  if (push_ready) begin
                     next_s.step = PAGE_WORD_BITS'(1);
                  end
               end else if (!s.fuse_hi[hvpp_pkg::PRESERVE_EE_BIT]) begin
                  // Preserve fuse programmed: EEPROM left alone
                  push_valid = 1'b0;
                  next_s.st  = ST_DRAIN;
               end else begin
                  push_op.op = hvpp_pkg::OP_ERASE_EE;
                  if (push_ready) begin
                     next_s.st = ST_DRAIN;
                  end
               end
            end
            ST_DRAIN: begin
               if (fifo_empty && NVM_IDLE) begin
                  if (s.erase) begin
                     // Lock cleared after memories
                     push_valid   = 1'b1;
                     push_op.op   = hvpp_pkg::OP_LOCK;
                     push_op.data = {8'h00, hvpp_pkg::ERASED_BYTE};
                     if (push_ready) begin
                        next_s.lock  = hvpp_pkg::ERASED_BYTE;
                        next_s.erase = 1'b0;
                     end
                  end else begin
                     next_s.st = ST_IDLE;
                  end
               end
            end
            default: begin
               next_s.st = ST_IDLE;
            end
         endcase
      end

      // Read path, every cycle
      next_s.oe    = s.prog && PROG_HV && !OUTPUT_ENABLE_N;
      next_s.raddr = word_addr;
      next_s.dout  = hvpp_pkg::ERASED_BYTE;
      next_s.space = hvpp_pkg::SPACE_FLASH;
      case (s.cmd)
         hvpp_pkg::CMD_READ_FLASH: begin
            next_s.dout = BYTE_SELECT_FIRST ? RD_DATA[15:8] : RD_DATA[7:0];
         end
         hvpp_pkg::CMD_READ_EEPROM: begin
            next_s.space = hvpp_pkg::SPACE_EEPROM;
            next_s.dout  = RD_DATA[7:0];
         end
         hvpp_pkg::CMD_READ_SIG: begin
            next_s.space = hvpp_pkg::SPACE_SIG;
            next_s.dout  = BYTE_SELECT_FIRST ? RD_DATA[15:8] : RD_DATA[7:0];
         end
         hvpp_pkg::CMD_READ_FUSE: begin
            case ({BYTE_SELECT_SECOND, BYTE_SELECT_FIRST})
               2'h0:    next_s.dout = s.fuse_lo;
               2'h1:    next_s.dout = s.lock;
               2'h2:    next_s.dout = s.fuse_ext;
               default: next_s.dout = s.fuse_hi;
            endcase
         end
         default: begin
         end
      endcase
      next_s.rdy = (next_s.st == ST_IDLE);
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         s          <= '0;
         s.st       <= ST_IDLE;
         s.wr_d     <= 1'b1;
         s.page     <= {PAGE_WORDS{hvpp_pkg::ERASED_WORD}};
         s.ee_page  <= {hvpp_pkg::EE_PAGE_BYTES{hvpp_pkg::ERASED_BYTE}};
         s.fuse_lo  <= hvpp_pkg::FUSE_LOW_RESET;
         s.fuse_hi  <= hvpp_pkg::FUSE_HIGH_RESET;
         s.fuse_ext <= hvpp_pkg::FUSE_EXT_RESET;
         s.lock     <= hvpp_pkg::LOCK_RESET;
         s.rdy      <= 1'b1;
         s.dout     <= hvpp_pkg::ERASED_BYTE;
      end else begin
         s <= next_s;
      end
   end
endmodule
